//--- pkg/scis_pkg.sv
// shared constants for the channel interrupt service block
package scis_pkg;
	// interrupt type bit positions, highest priority in the top bit
	localparam int TYPE_W      = 6;
	localparam int T_RX_STAT   = 5;
	localparam int T_RX_DATA   = 4;
	localparam int T_TX_STAT   = 3;
	localparam int T_TX_DATA   = 2;
	localparam int T_IO_PIN    = 1;
	localparam int T_MISC      = 0;

	// chain control register fields
	localparam int CC_SEL_LSB  = 0;
	localparam int CC_OP_LSB   = 6;
	localparam int CC_US_LSB   = 8;
	localparam int CC_UOP_LSB  = 14;
	localparam logic [1:0] OP_CLR_BOTH = 2'h1;
	localparam logic [1:0] OP_CLR      = 2'h2;
	localparam logic [1:0] OP_SET      = 2'h3;

	// channel command register command field
	localparam int CMD_LSB     = 11;
	localparam int CMD_W       = 5;
	localparam logic [4:0] CMD_RST_HIGH_US = 5'h02;
	localparam logic [4:0] CMD_PURGE_RX    = 5'h08;

	// status byte and split of the misc status byte
	localparam int STAT_W      = 8;
	localparam int IOP_W       = 4;

	// receive side fields
	localparam int LVL_LSB     = 8;
	localparam int LVL_W       = 5;
	localparam int FILL_LSB    = 8;
	localparam int RDF_LSB     = 8;
	localparam int EOF_BIT     = 8;
	localparam int CHAR_W      = 8;
	localparam int RX_DEPTH    = 32;
	localparam logic [4:0] MIN_LVL_WIDE = 5'h01;
endpackage

//--- rtl/scis_channel.sv
// channel interrupt service: pending and under-service latches, status arming, receive queue
// What this block does
// - ack with chain enable high sets under-service of highest pending requesting type
// - pending bits read in chain control low byte; high byte write sets under-service
// - set under-service blocks requests of that type and all lower types
// - writing ones to rx/tx status low byte clears those latched bits
// - writing ones to misc status low byte clears those bits, armed or not
// - arm bits gate status sources; zero disarms; re-arming a set bit interrupts again
// - frame mode raises receive-data interrupt at frame end and at fill level
// - receive interrupt control register reads back current queue fill level
// - on a 16-bit bus the least request level is code 01, two characters
// - wide read with oldest character ending a frame removes only that character
// - read status shows byte-end and boundary flags when read held frame end
// - purge command empties the receive queue
// - reset-highest command clears highest set under-service latch
// - pending op: 00 none, 01 clear both, 10 clear, 11 set on selected types
module scis_channel #(
	parameter int DEPTH = scis_pkg::RX_DEPTH
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_int_ack_n,
	input  wire logic        i_chain_enable_in,
	input  wire logic        i_bus16,
	input  wire logic        i_frame_mode,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_chain_wr_lo,
	input  wire logic        i_chain_wr_hi,
	input  wire logic        i_rx_csr_wr_lo,
	input  wire logic        i_tx_csr_wr_lo,
	input  wire logic        i_misc_wr_lo,
	input  wire logic        i_rx_icr_wr_lo,
	input  wire logic        i_rx_icr_wr_hi,
	input  wire logic        i_tx_icr_wr_lo,
	input  wire logic        i_status_int_control_reg_wr_lo,
	input  wire logic        i_chan_cmd_wr,
	input  wire logic [7:0]  i_rx_status_set,
	input  wire logic [7:0]  i_tx_status_set,
	input  wire logic [7:0]  i_misc_status_set,
	input  wire logic        i_tx_data_req,
	input  wire logic        i_rx_char_valid,
	input  wire logic [7:0]  i_rx_char,
	input  wire logic        i_rx_char_eof,
	input  wire logic        i_rx_rd,
	input  wire logic        i_rx_rd_wide,
	output logic      [15:0] o_chain_control_reg,
	output logic      [15:0] o_rx_cmd_status_reg,
	output logic      [15:0] o_tx_cmd_status_reg,
	output logic      [15:0] o_misc_int_status_reg,
	output logic      [15:0] o_rx_int_control_reg,
	output logic      [15:0] o_rx_data_reg,
	output logic             o_int_req
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam int EW = scis_pkg::CHAR_W + 1;

	logic [5:0]    pend;
	logic [5:0]    us;
	logic [5:0]    blocked;
	logic [5:0]    req_vec;
	logic [5:0]    hi_req;
	logic [5:0]    hi_us;
	logic [5:0]    hw_set;
	logic [5:0]    ack_set;
	logic [5:0]    sw_set_us;
	logic [5:0]    clr_us;
	logic [5:0]    clr_p;
	logic [5:0]    set_p;
	logic [2:0]    ack_sync;
	logic [2:0]    ien_sync;
	logic          ack_lvl;
	logic          ien_lvl;
	logic          ack_prev;
	logic          ack_edge;
	logic [7:0]    rx_stat;
	logic [7:0]    tx_stat;
	logic [7:0]    misc_stat;
	logic [7:0]    rx_arm;
	logic [7:0]    tx_arm;
	logic [7:0]    misc_arm;
	logic [3:0]    armed_prev;
	logic [3:0]    armed_now;
	logic          tx_req_prev;
	logic [4:0]    req_level;
	logic [EW-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [EW-1:0] old_ch;
	logic [EW-1:0] nxt_ch;
	logic          rd_ok;
	logic          pop2;
	logic          push;
	logic          purge;
	logic          rst_high;
	logic [CW-1:0] pop_n;
	logic [CW-1:0] thr;
	logic [4:0]    eff_lvl;
	logic          at_lvl;
	logic          at_lvl_prev;
	logic          first_be;
	logic          second_be;
	logic          bound;

	// pins from outside: three flops, change accepted when second and third agree
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ack_sync <= 3'h7;
			ien_sync <= 3'h0;
			ack_lvl  <= 1'b1;
			ien_lvl  <= 1'b0;
			ack_prev <= 1'b1;
		end else begin
			ack_sync <= {ack_sync[1:0], i_int_ack_n};
			ien_sync <= {ien_sync[1:0], i_chain_enable_in};
			if (ack_sync[1] == ack_sync[2]) begin
				ack_lvl <= ack_sync[2];
			end
			if (ien_sync[1] == ien_sync[2]) begin
				ien_lvl <= ien_sync[2];
			end
			ack_prev <= ack_lvl;
		end
	end
	assign ack_edge = ack_prev & ~ack_lvl; // falling edge starts an acknowledge

	// per-type priority: blocking mask and highest-one selects
	genvar gi;
	generate
		for (gi = 0; gi < scis_pkg::TYPE_W; gi++) begin : g_prio
			assign blocked[gi] = |us[5:gi];
			assign hi_req[gi]  = req_vec[gi] & ~|(req_vec >> (gi + 1));
			assign hi_us[gi]   = us[gi] & ~|(us >> (gi + 1));
		end
	endgenerate
	assign req_vec = pend & ~blocked;

	// software and acknowledge terms on the two latch sets
	assign rst_high  = i_chan_cmd_wr &&
		(i_wdata[scis_pkg::CMD_LSB +: scis_pkg::CMD_W] == scis_pkg::CMD_RST_HIGH_US);
	assign purge     = i_chan_cmd_wr &&
		(i_wdata[scis_pkg::CMD_LSB +: scis_pkg::CMD_W] == scis_pkg::CMD_PURGE_RX);
	assign ack_set   = (ack_edge && ien_lvl && o_int_req) ? hi_req : 6'h00;
	assign sw_set_us = (i_chain_wr_hi && i_wdata[scis_pkg::CC_UOP_LSB +: 2] == scis_pkg::OP_SET)
		? i_wdata[scis_pkg::CC_US_LSB +: 6] : 6'h00;
	assign clr_us    = ((i_chain_wr_hi && i_wdata[scis_pkg::CC_UOP_LSB +: 2] == scis_pkg::OP_CLR)
		? i_wdata[scis_pkg::CC_US_LSB +: 6] : 6'h00)
		| ((i_chain_wr_lo && i_wdata[scis_pkg::CC_OP_LSB +: 2] == scis_pkg::OP_CLR_BOTH)
		? i_wdata[scis_pkg::CC_SEL_LSB +: 6] : 6'h00)
		| (rst_high ? hi_us : 6'h00);
	assign clr_p     = (i_chain_wr_lo && (i_wdata[scis_pkg::CC_OP_LSB +: 2] == scis_pkg::OP_CLR
		|| i_wdata[scis_pkg::CC_OP_LSB +: 2] == scis_pkg::OP_CLR_BOTH))
		? i_wdata[scis_pkg::CC_SEL_LSB +: 6] : 6'h00;
	assign set_p     = (i_chain_wr_lo && i_wdata[scis_pkg::CC_OP_LSB +: 2] == scis_pkg::OP_SET)
		? i_wdata[scis_pkg::CC_SEL_LSB +: 6] : 6'h00;

	// latches: software clear beats software set, acknowledge and hardware sets win over clears
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			pend      <= 6'h00;
			us        <= 6'h00;
			o_int_req <= 1'b0;
		end else begin
			pend      <= (pend & ~clr_p) | set_p | hw_set;
			us        <= ((us | sw_set_us) & ~clr_us) | ack_set;
			o_int_req <= |req_vec;
		end
	end

	// latched status bytes, write ones to clear; a new event the same cycle stays set
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rx_stat   <= 8'h00;
			tx_stat   <= 8'h00;
			misc_stat <= 8'h00;
		end else begin
			rx_stat   <= (rx_stat & ~(i_rx_csr_wr_lo ? i_wdata[7:0] : 8'h00))
				| i_rx_status_set;
			tx_stat   <= (tx_stat & ~(i_tx_csr_wr_lo ? i_wdata[7:0] : 8'h00))
				| i_tx_status_set;
			misc_stat <= (misc_stat & ~(i_misc_wr_lo ? i_wdata[7:0] : 8'h00))
				| i_misc_status_set;
		end
	end

	// arm bytes and receive request level
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rx_arm    <= 8'h00;
			tx_arm    <= 8'h00;
			misc_arm  <= 8'h00;
			req_level <= 5'h00;
		end else begin
			if (i_rx_icr_wr_lo) begin
				rx_arm <= i_wdata[7:0];
			end
			if (i_tx_icr_wr_lo) begin
				tx_arm <= i_wdata[7:0];
			end
			if (i_status_int_control_reg_wr_lo) begin
				misc_arm <= i_wdata[7:0];
			end
			if (i_rx_icr_wr_hi) begin
				req_level <= i_wdata[scis_pkg::LVL_LSB +: scis_pkg::LVL_W];
			end
		end
	end

	// a rising armed term raises pending, so disarm then re-arm retriggers a set bit
	assign armed_now = {|(rx_stat & rx_arm), |(tx_stat & tx_arm),
		|(misc_stat[scis_pkg::IOP_W-1:0] & misc_arm[scis_pkg::IOP_W-1:0]),
		|(misc_stat[7:scis_pkg::IOP_W] & misc_arm[7:scis_pkg::IOP_W])};
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			armed_prev  <= 4'h0;
			tx_req_prev <= 1'b0;
			at_lvl_prev <= 1'b0;
		end else begin
			armed_prev  <= armed_now;
			tx_req_prev <= i_tx_data_req;
			at_lvl_prev <= at_lvl;
		end
	end
	always_comb begin
		hw_set = 6'h00;
		hw_set[scis_pkg::T_RX_STAT] = armed_now[3] & ~armed_prev[3];
		hw_set[scis_pkg::T_TX_STAT] = armed_now[2] & ~armed_prev[2];
		hw_set[scis_pkg::T_IO_PIN]  = armed_now[1] & ~armed_prev[1];
		hw_set[scis_pkg::T_MISC]    = armed_now[0] & ~armed_prev[0];
		hw_set[scis_pkg::T_TX_DATA] = i_tx_data_req & ~tx_req_prev;
		hw_set[scis_pkg::T_RX_DATA] = (at_lvl & ~at_lvl_prev)
			| (i_frame_mode & push & i_rx_char_eof);
	end

	// request threshold: code n means n+1 characters; wide bus floors the code at 01
	assign eff_lvl = (i_bus16 && req_level < scis_pkg::MIN_LVL_WIDE)
		? scis_pkg::MIN_LVL_WIDE : req_level;
	assign thr     = CW'(eff_lvl) + CW'(1);
	assign at_lvl  = (count >= thr);

	// receive queue pop: a frame-end oldest character always leaves alone
	assign old_ch = mem[rd_ptr];
	assign nxt_ch = mem[rd_ptr + PW'(1)];
	assign rd_ok  = i_rx_rd && (count != '0);
	assign pop2   = rd_ok && i_rx_rd_wide && i_bus16 && !old_ch[scis_pkg::EOF_BIT]
		&& (count >= CW'(2));
	assign pop_n  = rd_ok ? (pop2 ? CW'(2) : CW'(1)) : '0;
	assign push   = i_rx_char_valid && (count < CW'(DEPTH)) && !purge; // full queue drops

	// queue storage, written only, never reset
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= {i_rx_char_eof, i_rx_char};
		end
	end

	// queue pointers and fill count
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (purge) begin
			rd_ptr <= wr_ptr;
			count  <= '0;
		end else begin
			wr_ptr <= wr_ptr + PW'(push);
			rd_ptr <= rd_ptr + pop_n[PW-1:0];
			count  <= count + CW'(push) - pop_n;
		end
	end

	// read data and byte-end flags, held until the next read
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_rx_data_reg <= 16'h0000;
			first_be      <= 1'b0;
			second_be     <= 1'b0;
			bound         <= 1'b0;
		end else if (rd_ok) begin
			o_rx_data_reg <= {pop2 ? nxt_ch[7:0] : 8'h00, old_ch[7:0]};
			first_be      <= !pop2 && old_ch[scis_pkg::EOF_BIT];
			second_be     <= pop2 && nxt_ch[scis_pkg::EOF_BIT];
			bound         <= pop2 ? nxt_ch[scis_pkg::EOF_BIT]
				: old_ch[scis_pkg::EOF_BIT];
		end
	end

	// read views; upper bits not listed read zero
	assign o_chain_control_reg   = {2'h0, us, 2'h0, pend};
	assign o_rx_cmd_status_reg   = {5'h00, bound, second_be, first_be, rx_stat};
	assign o_tx_cmd_status_reg   = {8'h00, tx_stat};
	assign o_misc_int_status_reg = {8'h00, misc_stat};
	assign o_rx_int_control_reg  = {{(8 - CW){1'b0}}, count, rx_arm};

	property p_ack_sets;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(ack_edge && ien_lvl && o_int_req) |=> ((us & $past(hi_req)) == $past(hi_req));
	endproperty
	a_ack_sets: assert property (p_ack_sets) else $error("ack did not set under-service");

	property p_block;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(pend == (pend & blocked)) |=> !o_int_req;
	endproperty
	a_block: assert property (p_block) else $error("request while all pending blocked");

	property p_w1c;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_rx_csr_wr_lo && i_rx_status_set == 8'h00)
			|=> ((rx_stat & $past(i_wdata[7:0])) == 8'h00);
	endproperty
	a_w1c: assert property (p_w1c) else $error("status bit survived write of one");

	property p_misc_w1c;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_misc_wr_lo && i_misc_status_set == 8'h00)
			|=> ((misc_stat & $past(i_wdata[7:0])) == 8'h00);
	endproperty
	a_misc_w1c: assert property (p_misc_w1c) else $error("misc bit survived write");

	property p_rearm;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(rx_arm == 8'h00 && i_rx_icr_wr_lo && (rx_stat & i_wdata[7:0]) != 8'h00)
			|=> ##1 pend[scis_pkg::T_RX_STAT];
	endproperty
	a_rearm: assert property (p_rearm) else $error("re-arm gave no status interrupt");

	property p_frame_end;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_frame_mode && push && i_rx_char_eof) |=> pend[scis_pkg::T_RX_DATA];
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame end raised no rx data");

	property p_lone_pop;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(rd_ok && !purge && !push && old_ch[scis_pkg::EOF_BIT])
			|=> (count == $past(count) - CW'(1));
	endproperty
	a_lone_pop: assert property (p_lone_pop) else $error("frame end popped with partner");

	property p_purge;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		purge |=> (count == '0) && (o_rx_int_control_reg[scis_pkg::FILL_LSB +: CW] == '0);
	endproperty
	a_purge: assert property (p_purge) else $error("purge left characters");

	property p_rst_high;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(rst_high && us != 6'h00 && ack_set == 6'h00 && !i_chain_wr_hi)
			|=> ((us & $past(hi_us)) == 6'h00);
	endproperty
	a_rst_high: assert property (p_rst_high) else $error("highest under-service not cleared");

	property p_set_pend;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_chain_wr_lo && i_wdata[scis_pkg::CC_OP_LSB +: 2] == scis_pkg::OP_SET)
			|=> ((pend & $past(i_wdata[5:0])) == $past(i_wdata[5:0]));
	endproperty
	a_set_pend: assert property (p_set_pend) else $error("pending set op failed");
endmodule

//--- testbench/scis_host_chain.sv
// host side model: acknowledge cycles and upstream daisy chain
module scis_host_chain #(
	parameter int LOW_CYC = 6
) (
	input  wire logic i_sys_clk,
	input  wire logic i_int_req,
	input  wire logic i_allow,
	input  wire logic i_upstream_busy,
	output logic      o_ack_n,
	output logic      o_chain_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;

	// an upstream device in service pulls the chain low
	assign o_chain_enable = !i_upstream_busy;

	// acknowledge low while the count runs, long enough for the sync flops
	assign o_ack_n = (cnt == 0);

	// one acknowledge pulse per allowed request
	always @(posedge i_sys_clk) begin
		if (cnt != 0) begin
			cnt <= cnt - 1;
		end else if (i_int_req && i_allow) begin
			cnt <= LOW_CYC;
		end
	end
endmodule

//--- testbench/testbench.sv
// self-checking bench for the channel interrupt service block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CLO = 0, CHI = 1, RX_CMD_STATUS_REG = 2, TX_CMD_STATUS_REG = 3, MISC = 4;
	localparam int RILO = 5, RIHI = 6, TILO = 7, SILO = 8, CMD = 9;
	logic        clk = 0, rst = 1, allow = 0, busy = 0, b16 = 0, fm = 0;
	logic        txq = 0, cv = 0, ceof = 0, rd = 0, rw = 0;
	logic [15:0] wd = 16'h0;
	logic [9:0]  stb = 10'h0;
	logic [7:0]  rs = 8'h0, ts = 8'h0, ms = 8'h0, ch = 8'h0;
	wire logic        ack_n, cen, irq;
	wire logic [15:0] cc, rcs, tcs, mis, ric, rx_data_reg;
	int n_fail = 0, num_checks = 0, cyc = 0;

	scis_channel dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_int_ack_n(ack_n),
		.i_chain_enable_in(cen), .i_bus16(b16), .i_frame_mode(fm), .i_wdata(wd),
		.i_chain_wr_lo(stb[0]), .i_chain_wr_hi(stb[1]), .i_rx_csr_wr_lo(stb[2]),
		.i_tx_csr_wr_lo(stb[3]), .i_misc_wr_lo(stb[4]), .i_rx_icr_wr_lo(stb[5]),
		.i_rx_icr_wr_hi(stb[6]), .i_tx_icr_wr_lo(stb[7]), .i_status_int_control_reg_wr_lo(stb[8]),
		.i_chan_cmd_wr(stb[9]), .i_rx_status_set(rs), .i_tx_status_set(ts),
		.i_misc_status_set(ms), .i_tx_data_req(txq), .i_rx_char_valid(cv),
		.i_rx_char(ch), .i_rx_char_eof(ceof), .i_rx_rd(rd), .i_rx_rd_wide(rw),
		.o_chain_control_reg(cc), .o_rx_cmd_status_reg(rcs), .o_tx_cmd_status_reg(tcs),
		.o_misc_int_status_reg(mis), .o_rx_int_control_reg(ric), .o_rx_data_reg(rx_data_reg),
		.o_int_req(irq));

	scis_host_chain host (.i_sys_clk(clk), .i_int_req(irq), .i_allow(allow),
		.i_upstream_busy(busy), .o_ack_n(ack_n), .o_chain_enable(cen));

	// 20 MHz clock
	initial begin
		forever #25 clk = !clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			$display("unexpected at %0t: run did not finish", $time);
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
			n_fail++;
		end
	endtask

	// pending and request lag the register update by up to two cycles
	task automatic settle;
		repeat (3) @(negedge clk);
	endtask

	task automatic wr(input int s, input logic [15:0] d);
		@(negedge clk);
		wd     = d;
		stb[s] = 1'b1;
		@(negedge clk);
		stb = 10'h0;
		settle();
	endtask

	// one-cycle status set events on rx, tx or misc
	task automatic ev(input int w, input logic [7:0] b);
		@(negedge clk);
		if (w == 0) rs = b;
		else if (w == 1) ts = b;
		else ms = b;
		@(negedge clk);
		rs = 8'h0;
		ts = 8'h0;
		ms = 8'h0;
		settle();
	endtask

	task automatic push(input logic [7:0] c, input logic e);
		@(negedge clk);
		ch   = c;
		ceof = e;
		cv   = 1'b1;
		@(negedge clk);
		cv = 1'b0;
		settle();
	endtask

	task automatic rdq(input logic w);
		@(negedge clk);
		rw = w;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		settle();
	endtask

	// acknowledge cycle through the host model; busy holds the chain low
	task automatic ack(input logic b);
		@(negedge clk);
		busy  = b;
		allow = 1'b1;
		@(negedge clk);
		allow = 1'b0;
		repeat (14) @(negedge clk);
		busy = 1'b0;
		settle();
	endtask

	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		settle();
		chk(cc, 16'h0, "chain reset");
		chk({15'h0, irq}, 16'h0, "request reset");
		wr(RILO, 16'h0001);
		txq = 1'b1;
		ev(0, 8'h01);
		chk(cc, 16'h0024, "rx status and tx data pending");
		chk({15'h0, irq}, 16'h1, "request raised");
		ack(1'b1);
		chk(cc, 16'h0024, "ack with chain low");
		ack(1'b0);
		chk(cc, 16'h2024, "ack picks highest");
		chk({15'h0, irq}, 16'h0, "lower type held off");
		wr(CLO, 16'h00a0);
		chk(cc, 16'h2004, "pending cleared first");
		chk(rcs, 16'h0001, "rx status latched");
		wr(RX_CMD_STATUS_REG, 16'h0001);
		chk(rcs, 16'h0000, "rx status unlatched");
		wr(CMD, 16'h1000);
		chk(cc, 16'h0004, "reset highest under service");
		chk({15'h0, irq}, 16'h1, "tx data requests again");
		wr(CLO, 16'h0084);
		chk({15'h0, irq}, 16'h0, "request dropped");
		wr(CLO, 16'h00c3);
		chk(cc, 16'h0003, "set pending");
		wr(CLO, 16'h0041);
		chk(cc, 16'h0002, "clear both");
		wr(CHI, 16'hc200);
		chk(cc, 16'h0202, "software sets under service");
		chk({15'h0, irq}, 16'h0, "same type held off");
		wr(CHI, 16'h8200);
		wr(CLO, 16'h0082);
		chk(cc, 16'h0000, "all cleared");
		ev(0, 8'h02);
		chk(cc, 16'h0000, "unarmed source silent");
		wr(RILO, 16'h0000);
		wr(RILO, 16'h0002);
		chk(cc, 16'h0020, "re-arm interrupts again");
		chk({8'h0, ric[7:0]}, 16'h0002, "rx arm readback");
		wr(CLO, 16'h00a0);
		wr(RX_CMD_STATUS_REG, 16'h0002);
		wr(TILO, 16'h0001);
		ev(1, 8'h01);
		chk(cc, 16'h0008, "tx status pending");
		wr(TX_CMD_STATUS_REG, 16'h0001);
		chk(tcs, 16'h0000, "tx status unlatched");
		wr(CLO, 16'h0088);
		ev(2, 8'h80);
		chk(mis, 16'h0080, "misc latched unarmed");
		wr(MISC, 16'h0080);
		chk(mis, 16'h0000, "unarmed bit cleared");
		wr(SILO, 16'h0001);
		ev(2, 8'h01);
		chk(cc, 16'h0002, "io pin pending");
		wr(MISC, 16'h0001);
		chk(mis, 16'h0000, "armed bit cleared");
		wr(CLO, 16'h0082);
		// receive side on a wide bus in frame mode, least request level
		b16 = 1'b1;
		fm  = 1'b1;
		wr(RIHI, 16'h0100);
		push(8'h11, 1'b0);
		chk(cc, 16'h0000, "one char below level");
		push(8'h22, 1'b0);
		chk(cc, 16'h0010, "two chars reach level");
		chk({10'h0, ric[13:8]}, 16'h0002, "fill level");
		rdq(1'b1);
		chk(rx_data_reg, 16'h2211, "pair read");
		chk(rcs, 16'h0000, "no boundary");
		wr(CLO, 16'h0090);
		push(8'h33, 1'b1);
		chk(cc, 16'h0010, "frame end interrupts");
		push(8'h44, 1'b0);
		rdq(1'b1);
		chk(rx_data_reg, 16'h0033, "wide read stops at frame end");
		chk({10'h0, ric[13:8]}, 16'h0001, "one char left");
		chk(rcs, 16'h0500, "first byte end and boundary");
		push(8'h55, 1'b1);
		rdq(1'b1);
		chk(rx_data_reg, 16'h5544, "pair with frame end");
		chk(rcs, 16'h0600, "second byte end and boundary");
		// lone frame end: a fill of 01 means the host reads one character
		push(8'h88, 1'b1);
		chk({10'h0, ric[13:8]}, 16'h0001, "lone frame end char");
		rdq(1'b0);
		chk(rx_data_reg, 16'h0088, "single read of frame end");
		chk(rcs, 16'h0500, "single read flags");
		wr(CLO, 16'h0090);
		chk({10'h0, ric[13:8]}, 16'h0000, "fill re-read after drain");
		push(8'h66, 1'b0);
		push(8'h77, 1'b0);
		chk(cc, 16'h0010, "later rx data interrupt");
		wr(CMD, 16'h4000);
		chk({10'h0, ric[13:8]}, 16'h0000, "purge empties queue");
		// level code 00: two chars on a wide bus, one char on a narrow bus
		wr(CLO, 16'h0090);
		wr(RIHI, 16'h0000);
		push(8'h99, 1'b0);
		chk(cc, 16'h0000, "wide bus floors level");
		b16 = 1'b0;
		settle();
		chk(cc, 16'h0010, "narrow bus one char level");
		push(8'haa, 1'b0);
		rdq(1'b1);
		chk(rx_data_reg, 16'h0099, "narrow bus reads one char");
		chk({10'h0, ric[13:8]}, 16'h0001, "one char after narrow read");
		end_sim();
	end
endmodule
